/* File: verilog/ess_params.svh */
// Constants for the ethernet global status register block.
// Assumes inclusion by bare name from design files.
`ifndef ESS_PARAMS_SVH
`define ESS_PARAMS_SVH

`define ESS_BIT_PENDING 7
`define ESS_BIT_BUFERR 6
`define ESS_BIT_RSVD 5
`define ESS_BIT_LATE_COLLISION_FLAG 4
`define ESS_BIT_UNIMP 3
`define ESS_BIT_RXACT 2
`define ESS_BIT_TRANSMIT_ABORT_FLAG 1
`define ESS_BIT_CLOCK_READY 0
`define ESS_LATE_BYTES 16'h0040
`define ESS_STARTUP_NS 300000
`define ESS_CLK_NS 40
`define ESS_STARTUP_CYC ((`ESS_STARTUP_NS + `ESS_CLK_NS - 1) / `ESS_CLK_NS)
`define ESS_REG_RESET 8'h00
`define ESS_CLEAR_MASK 8'h52
`define ESS_IRQ_SRC_W 6

`endif

/* File: verilog/ess_pkg.sv */
// Types for the ethernet global status register block.
// Assumes ess_params.svh is available on the include path.
package ess_pkg;

	// Hardware events that feed the status flags
	typedef struct packed {
		logic buf_overrun;
		logic buf_underrun;
		logic collision;
		logic rx_active;
		logic tx_abort;
		logic phy_ready;
	} ess_events_type;

	// Host register access strobes
	typedef struct packed {
		logic rd;
		logic bit_clear;
		logic wr;
		logic [7:0] data;
	} ess_access_type;

	typedef enum logic [1:0] {
		ESS_ST_WAIT = 2'b00,
		ESS_ST_READY = 2'b01
	} ess_clk_state_type;

endpackage

/* File: verilog/ess_sync.sv */
// Three-stage synchroniser for asynchronous level inputs.
// Assumes one clock; output changes once stages two and three agree.
`timescale 1ns/10ps
module ess_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic async_i,
	output logic sync_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				sync_o <= s3_q;
			end
		end
	end
endmodule // ess_sync

/* File: verilog/ess_status.sv */
// Ethernet global status register with its flag logic.
// Assumes host access strobes are single-cycle and on clk_i.
`timescale 1ns/10ps
`include "ess_params.svh"
module ess_status (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	input wire ess_pkg::ess_events_type ev_i,
	input wire logic [15:0] tx_byte_count_i,
	input wire logic [5:0] irq_flags_i,
	input wire logic [5:0] irq_enable_register_i,
	input wire logic global_irq_enable_i,
	input wire ess_pkg::ess_access_type acc_i,
	output logic [7:0] ethernet_global_status_o,
	output logic irq_n_o
);
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	// Bit map: b7 pending, b6 buffer error, b5 reserved, b4 late collision,
	// b3 unused, b2 receive active, b1 transmit abort, b0 clock ready
	localparam logic [7:0] CLEARABLE = `ESS_CLEAR_MASK;
	localparam int IRQ_W = `ESS_IRQ_SRC_W;
	logic phy_ready_s;
	logic clock_ready_q;
	logic clock_ready_d;
	logic [31:0] timer_q;
	logic [31:0] timer_d;
	ess_pkg::ess_clk_state_type cstate_q;
	ess_pkg::ess_clk_state_type cstate_d;
	logic [7:0] set_vec_w;
	logic [7:0] flag_q;
	wire [7:0] flag_d;
	wire [IRQ_W-1:0] irq_hit_w;
	logic [7:0] status_w;

	// ----------------------------------------
	// Event qualification
	// ----------------------------------------
	// Only the ready level comes from another domain; the rest share clk_i
	ess_sync u_phy_sync (
		.clk_i(clk_i),
		.rst_n_i(por_n_i),
		.async_i(ev_i.phy_ready),
		.sync_o(phy_ready_s)
	);

	wire buf_event_w = ev_i.buf_overrun | ev_i.buf_underrun;
	wire late_event_w = ev_i.collision & (tx_byte_count_i >= `ESS_LATE_BYTES);

	// Set sources by register position; positions without a source stay low
	always_comb begin
		set_vec_w = `ESS_REG_RESET;
		set_vec_w[`ESS_BIT_BUFERR] = buf_event_w;
		set_vec_w[`ESS_BIT_LATE_COLLISION_FLAG] = late_event_w;
		set_vec_w[`ESS_BIT_TRANSMIT_ABORT_FLAG] = ev_i.tx_abort;
	end

	// ----------------------------------------
	// Interrupt summary
	// ----------------------------------------
	// One enabled-and-asserted term per source, then a plain OR
	genvar gs;
	generate
		for (gs = 0; gs < IRQ_W; gs++) begin : g_irq_src
			assign irq_hit_w[gs] = irq_flags_i[gs] & irq_enable_register_i[gs];
		end
	endgenerate
	wire irq_any_w = |irq_hit_w;

	// ----------------------------------------
	// Host clears
	// ----------------------------------------
	// Bit-clear clears ones in data, a write clears zeros; fixed bits ignore both
	wire [7:0] bc_mask_w = acc_i.bit_clear ? acc_i.data : `ESS_REG_RESET;
	wire [7:0] wr_mask_w = acc_i.wr ? ~acc_i.data : `ESS_REG_RESET;
	wire [7:0] clr_mask_w = (bc_mask_w | wr_mask_w) & CLEARABLE;

	// Hardware set wins, so an event landing on a clear is never lost
	function automatic logic flag_next(input logic cur, input logic set_ev, input logic clr);
		flag_next = set_ev | (cur & ~clr);
	endfunction

	// Only error positions carry state; others stay low whatever the host writes
	genvar gf;
	generate
		for (gf = 0; gf < 8; gf++) begin : g_flag
			if (CLEARABLE[gf]) begin : g_clear
				assign flag_d[gf] = flag_next(flag_q[gf], set_vec_w[gf], clr_mask_w[gf]);
			end else begin : g_fixed
				assign flag_d[gf] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_q <= `ESS_REG_RESET;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ----------------------------------------
	// Start-up timer, kept on power-on reset only
	// ----------------------------------------
	// Other resets leave this domain alone so the ready bit survives
	wire timer_done_w = (timer_q >= 32'(`ESS_STARTUP_CYC - 1));
	wire ready_go_w = timer_done_w & phy_ready_s;

	always_comb begin
		cstate_d = cstate_q;
		timer_d = timer_q;
		clock_ready_d = clock_ready_q;
		case (cstate_q)
			ess_pkg::ESS_ST_WAIT: begin
				if (!timer_done_w) begin
					timer_d = timer_q + 32'h1;
				end else if (ready_go_w) begin
					cstate_d = ess_pkg::ESS_ST_READY;
					clock_ready_d = 1'b1;
				end
			end
			ess_pkg::ESS_ST_READY: begin
				clock_ready_d = 1'b1;
			end
			default: begin
				cstate_d = ess_pkg::ESS_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			timer_q <= 32'h0;
			clock_ready_q <= 1'b0;
			cstate_q <= ess_pkg::ESS_ST_WAIT;
		end else begin
			timer_q <= timer_d;
			clock_ready_q <= clock_ready_d;
			cstate_q <= cstate_d;
		end
	end

	// ----------------------------------------
	// Register image
	// ----------------------------------------
	// Flags are taken from their next values so the registered image
	// shows an event on the same edge that sets the flag
	always_comb begin
		status_w = `ESS_REG_RESET;
		status_w[`ESS_BIT_PENDING] = irq_any_w;
		status_w[`ESS_BIT_BUFERR] = flag_d[`ESS_BIT_BUFERR];
		status_w[`ESS_BIT_LATE_COLLISION_FLAG] = flag_d[`ESS_BIT_LATE_COLLISION_FLAG];
		status_w[`ESS_BIT_RXACT] = ev_i.rx_active;
		status_w[`ESS_BIT_TRANSMIT_ABORT_FLAG] = flag_d[`ESS_BIT_TRANSMIT_ABORT_FLAG];
		status_w[`ESS_BIT_CLOCK_READY] = clock_ready_q;
		status_w[`ESS_BIT_RSVD] = 1'b0;
		status_w[`ESS_BIT_UNIMP] = 1'b0;
	end

	// ----------------------------------------
	// Interrupt pin
	// ----------------------------------------
	// Global enable gates only the pin, never the pending bit, so polling works
	wire irq_pin_n_w = ~(irq_any_w & global_irq_enable_i);

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ethernet_global_status_o <= `ESS_REG_RESET;
			irq_n_o <= 1'b1;
		end else begin
			ethernet_global_status_o <= status_w;
			irq_n_o <= irq_pin_n_w;
		end
	end
endmodule // ess_status

/* File: verif/ess_status_checker.sv */
// Port assertions for the ethernet global status register.
// Assumes it is bound to every ess_status instance.
`timescale 1ns/10ps
module ess_status_checker (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	input wire ess_pkg::ess_events_type ev_i,
	input wire logic [15:0] tx_byte_count_i,
	input wire logic [5:0] irq_flags_i,
	input wire logic [5:0] irq_enable_register_i,
	input wire logic global_irq_enable_i,
	input wire ess_pkg::ess_access_type acc_i,
	input wire logic [7:0] ethernet_global_status_o,
	input wire logic irq_n_o
);
	// ------------------------------------------
	// Properties, either reset silences them
	// ------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i || !por_n_i);
	wire [7:0] s = ethernet_global_status_o;
	wire late = ev_i.collision && tx_byte_count_i >= 16'h0040;
	a_spare_bits_zero: assert property (!s[5] && !s[3]) else $error("spare bit set");
	a_buf_err_set: assert property (ev_i.buf_overrun || ev_i.buf_underrun |=> s[6]) else $error("no buf flag");
	a_late_col_set: assert property (late |=> s[4]) else $error("no late flag");
	a_late_col_quiet: assert property (!s[4] && !late |=> !s[4]) else $error("stray late flag");
	a_rx_follows: assert property (1'b1 |=> s[2] == $past(ev_i.rx_active)) else $error("rx bit lag");
	a_abort_set: assert property (ev_i.tx_abort |=> s[1]) else $error("no abort flag");
	a_abort_clear: assert property (acc_i.bit_clear && acc_i.data[1] && !ev_i.tx_abort |=> !s[1])
		else $error("abort not cleared");
	a_ready_held: assert property (s[0] |=> s[0]) else $error("ready dropped");
	a_pend_set: assert property (|(irq_flags_i & irq_enable_register_i) |=> s[7]) else $error("no pending");
	a_irq_gated: assert property (!global_irq_enable_i |=> irq_n_o) else $error("irq not gated");
endmodule // ess_status_checker

bind ess_status ess_status_checker u_chk (.clk_i, .rst_n_i, .por_n_i, .ev_i, .tx_byte_count_i, .irq_flags_i,
	.irq_enable_register_i, .global_irq_enable_i, .acc_i, .ethernet_global_status_o, .irq_n_o);

/* File: verif/ethernet_status_register_bench.sv */
// Self-checking bench for the ethernet global status register.
// Assumes the design and checker files are compiled first.
`timescale 1ns/10ps
module ethernet_status_register_bench;
	logic clk_i = 0;
	logic rst_n_i = 0;
	logic por_n_i = 0;
	logic global_irq_enable_i = 0;
	ess_pkg::ess_events_type ev_i = '0;
	ess_pkg::ess_access_type acc_i = '0;
	logic [15:0] tx_byte_count_i = '0;
	logic [5:0] irq_flags_i = '0;
	logic [5:0] irq_enable_register_i = '0;
	logic [7:0] ethernet_global_status_o;
	logic irq_n_o;
	int errors = 0;
	int num_checks = 0;
	always #20 clk_i = ~clk_i;
	ess_status dut (.clk_i, .rst_n_i, .por_n_i, .ev_i, .tx_byte_count_i, .irq_flags_i, .irq_enable_register_i,
		.global_irq_enable_i, .acc_i, .ethernet_global_status_o, .irq_n_o);
	// ------------------------------------------
	// Tasks
	// ------------------------------------------
	task automatic chk(input string n, input logic [7:0] m, e);
		logic [7:0] seen;
		seen = (n == "irq") ? {7'h00, irq_n_o} : ethernet_global_status_o & m;
		num_checks++;
		if (seen !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, seen);
		end
	endtask
	// One-cycle events or access; phy_ready stays high
	task automatic go(input logic [5:0] e, input logic [10:0] a);
		@(posedge clk_i);
		ev_i <= e | 6'h01;
		acc_i <= a;
		@(posedge clk_i);
		ev_i <= 6'h01;
		acc_i <= '0;
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ------------------------------------------
	// Tests
	// ------------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1;
		por_n_i <= 1;
		ev_i <= 6'h01;
		for (int i = 0; i < 9000 && ethernet_global_status_o[0] !== 1'b1; i++) @(posedge clk_i);
		chk("ready", 8'h29, 8'h01);
		go(6'h02, '0);
		chk("abort", 8'h02, 8'h02);
		go('0, 11'h202);
		chk("abort", 8'h02, 8'h00);
		go(6'h02, 11'h202);
		chk("abort", 8'h02, 8'h02);
		go('0, 11'h202);
		chk("abort", 8'h02, 8'h00);
		go(6'h20, '0);
		chk("buf", 8'h40, 8'h40);
		go('0, 11'h1bf);
		chk("buf", 8'h41, 8'h01);
		go(6'h10, '0);
		chk("buf", 8'h40, 8'h40);
		go('0, 11'h240);
		chk("buf", 8'h40, 8'h00);
		tx_byte_count_i <= 16'h003f;
		go(6'h08, '0);
		chk("late", 8'h10, 8'h00);
		tx_byte_count_i <= 16'h0040;
		go(6'h08, '0);
		chk("late", 8'h10, 8'h10);
		go(6'h04, 11'h100);
		chk("rx", 8'h04, 8'h04);
		go('0, 11'h1ff);
		chk("rx", 8'h04, 8'h00);
		irq_flags_i <= 6'h01;
		irq_enable_register_i <= 6'h01;
		go('0, '0);
		chk("pend", 8'h80, 8'h80);
		chk("irq", 8'h01, 8'h01);
		global_irq_enable_i <= 1;
		go('0, '0);
		chk("irq", 8'h01, 8'h00);
		rst_n_i <= 0;
		go('0, '0);
		rst_n_i <= 1;
		go('0, '0);
		chk("ready", 8'h11, 8'h01);
		por_n_i <= 0;
		go('0, '0);
		por_n_i <= 1;
		go('0, '0);
		chk("ready", 8'h01, 8'h00);
		tally_and_finish();
	end
	// Startup wait dominates the run
	initial begin
		#480000;
		errors++;
		tally_and_finish();
	end
endmodule // ethernet_status_register_bench
